// *** verilog/acs_sequencer.sv ***
// sample/conversion sequencer with result fifo
// Behaviour
// - short sampling: 12 sclk after fourth fall
// - long sampling holds 44 sclk periods
// - trigger low samples, rise converts after delay
// - leave extended after two frame starts
// - conversion starts at fall 16/48 or trigger
// - conversion lasts 18 or 13 clocks plus delay
// - conv clock: oscillator or four sclk
// - busy low during conversion, flag at end
// - one shot: single conversion, no fifo
// - repeat fills fifo to threshold, flag
// - select during run is a dummy
// - repeat with trigger restarts immediately
// - sweep follows sequence, stops at threshold
// - sweep idles until read or config
// - arm select after read keeps sequence
// - repeat sweep restarts without read
// - frame: 4-bit command, optional 12 data
// - previous result 14/12 bits shifted out
// - threshold field selects 8/6/4/2 results
// - status pin: flag or busy, mode 00
// ------------------------------------------------------------------
// result fifo
// ------------------------------------------------------------------
module acs_fifo #(
  parameter int W = 14,
  parameter int D = 8
) (
  // clock, reset
  input  wire logic         i_core_clk,
  input  wire logic         i_rst,
  input  wire logic         i_flush,
  // fill side
  input  wire logic         i_valid,
  output logic              o_ready,
  input  wire logic [W-1:0] i_data,
  // drain side
  output logic              o_valid,
  input  wire logic         i_ready,
  output logic [W-1:0]      o_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem_r [D];
  logic [AW-1:0] wr_r, rd_r;
  logic [AW:0]   cnt_r;
  wire push = i_valid && o_ready;
  wire pop  = o_valid && i_ready;
  assign o_ready = cnt_r != (AW+1)'(D);
  assign o_valid = cnt_r != '0;
  assign o_data  = mem_r[rd_r];
  always_ff @(posedge i_core_clk) begin
    if (push) begin
      mem_r[wr_r] <= i_data;
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else if (i_flush) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      wr_r  <= wr_r + AW'(push);
      rd_r  <= rd_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
// ------------------------------------------------------------------
// sequencer top
// ------------------------------------------------------------------
module acs_sequencer (
  // clock, reset
  input  wire logic                       i_core_clk,
  input  wire logic                       i_rst,
  // serial link pins
  input  wire logic                       i_cs_n,
  input  wire logic                       i_frame_sync,
  input  wire logic                       i_sclk,
  input  wire logic                       i_serial_cmd_in,
  input  wire logic                       i_ext_sample_trigger_n,
  input  wire logic                       i_on_chip_conv_clock,
  output logic                            o_serial_result_out,
  output logic                            o_serial_result_oe,
  // converter core
  input  wire logic [acs_pkg::RES_W-1:0]  i_adc_result,
  input  wire logic                       i_res_12bit,
  output logic                            o_sample_en,
  output logic [2:0]                      o_adc_channel,
  // status
  output logic                            o_status_n,
  output logic                            o_conv_busy_n,
  output logic                            o_result_ready_flag_n
);
  function automatic logic [2:0] seq_chan(input logic [1:0] sel, input logic [2:0] idx);
    unique case (sel)
      2'b00: seq_chan = idx;
      2'b01: seq_chan = {idx[1:0], 1'b0};
      2'b10: seq_chan = {idx[2:1], 1'b0};
      2'b11: seq_chan = {1'b0, idx[0], 1'b0};
    endcase
  endfunction
  function automatic logic [3:0] thr_count(input logic [1:0] sel);
    unique case (sel)
      2'b00: thr_count = acs_pkg::THR_8;
      2'b01: thr_count = acs_pkg::THR_6;
      2'b10: thr_count = acs_pkg::THR_4;
      2'b11: thr_count = acs_pkg::THR_2;
    endcase
  endfunction
  acs_pkg::acs_state_t state_r, state_nxt;
  logic [5:0]  s1_r, s2_r, s3_r, stab_r, prev_r;
  logic [5:0]  fall_r;
  logic [11:0] sh_r, cfg_r;
  logic [1:0]  div_r, dly_r;
  logic [4:0]  conv_cnt_r;
  logic [6:0]  conv_falls_r;
  logic [3:0]  cnt_r;
  logic [2:0]  idx_r, chan_r;
  logic        run_r, halt_r, armed_r, ext_mode_r, ext_cnt_r;
  logic [acs_pkg::RES_W-1:0] last_r;
  logic [acs_pkg::OUT_W-1:0] out_sr_r;
  logic                      fifo_in_rdy, fifo_out_vld;
  logic [acs_pkg::RES_W-1:0] fifo_data;
  // ----------------------------------------------------------------
  // pin synchronisers and edges
  // ----------------------------------------------------------------
  // a level counts only once the second and third stage agree
  wire [5:0] pins = {i_serial_cmd_in, i_on_chip_conv_clock, i_ext_sample_trigger_n,
                     i_sclk, i_frame_sync, i_cs_n};
  wire [5:0] stab_nxt = (s2_r & s3_r) | (stab_r & (s2_r ^ s3_r));
  wire [5:0] rise = stab_r & ~prev_r;
  wire [5:0] fall = ~stab_r & prev_r;
  wire frame_start = fall[acs_pkg::PIN_CS] || rise[acs_pkg::PIN_FS];
  wire sclk_fall   = fall[acs_pkg::PIN_SCLK];
  wire trig_fall   = fall[acs_pkg::PIN_TRIG];
  wire trig_rise   = rise[acs_pkg::PIN_TRIG];
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire acs_pkg::acs_mode_t mode = acs_pkg::acs_mode_t'(cfg_r[acs_pkg::CFG_MODE_LSB +: 2]);
  wire        mode_one = mode == acs_pkg::MODE_ONE;
  wire        pinsel   = cfg_r[acs_pkg::CFG_PINSEL_BIT];
  wire        long_smp = cfg_r[acs_pkg::CFG_LONG_BIT];
  wire [1:0]  sweep    = cfg_r[acs_pkg::CFG_SWEEP_LSB +: 2];
  wire [3:0]  thr      = thr_count(cfg_r[acs_pkg::CFG_THR_LSB +: 2]);
  wire [5:0]  fall_nxt = (fall_r == 6'h3F) ? fall_r : fall_r + 6'h01;
  wire [11:0] sh_nxt   = {sh_r[10:0], stab_r[acs_pkg::PIN_SDI]};
  wire [3:0]  cmd      = sh_nxt[3:0];
  wire cmd_dec  = state_r == acs_pkg::ST_SETUP && sclk_fall && !frame_start &&
                  fall_nxt == acs_pkg::SETUP_FALLS;
  wire is_cfg   = cmd == acs_pkg::CMD_CFG_WR;
  wire is_read  = cmd == acs_pkg::CMD_FIFO_RD;
  wire is_sel   = !cmd[3];
  wire cfg_go   = state_r == acs_pkg::ST_CFG && sclk_fall && !frame_start &&
                  fall_nxt == acs_pkg::SETUP_FALLS + 6'(acs_pkg::CFG_W);
  wire samp_go  = cmd_dec && is_sel && !ext_mode_r && !halt_r;
  wire [5:0] samp_end = acs_pkg::SETUP_FALLS +
                  (long_smp ? acs_pkg::LONG_SAMPLE : acs_pkg::SHORT_SAMPLE);
  wire trig_go  = trig_fall && state_r == acs_pkg::ST_IDLE && armed_r && !halt_r;
  wire run_go   = !mode_one && !run_r && (samp_go || trig_go);
  wire conv_tick = cfg_r[acs_pkg::CFG_INTCLK_BIT] ? rise[acs_pkg::PIN_OSC] :
                   (sclk_fall && div_r == acs_pkg::SCLK_DIV_LAST);
  wire [4:0] conv_last = (i_res_12bit ? acs_pkg::CONV_CLK_12 : acs_pkg::CONV_CLK_14) - 5'h01;
  wire dly_done = dly_r == acs_pkg::DLY_LAST;
  wire fin_go   = state_r == acs_pkg::ST_FINISH && dly_done && !frame_start &&
                  (mode_one || fifo_in_rdy); // fifo back-pressure stalls the finish
  wire push     = fin_go && !mode_one;
  wire thr_hit  = push && (cnt_r + 4'h1 == thr);
  wire pop      = cmd_dec && is_read && fifo_out_vld;
  wire flag_nxt = (fin_go && (mode_one ? !pinsel : thr_hit)) ? 1'b0 :
                  (frame_start ? 1'b1 : o_result_ready_flag_n); // set wins
  wire busy_nxt = !(state_nxt == acs_pkg::ST_CONV || state_nxt == acs_pkg::ST_FINISH);
  wire [2:0] cur_chan = (mode == acs_pkg::MODE_SWEEP || mode == acs_pkg::MODE_RSWEEP) ?
                        seq_chan(sweep, idx_r) : chan_r;
  wire [acs_pkg::RES_W-1:0] out_src = (fifo_out_vld && !mode_one) ? fifo_data : last_r;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      acs_pkg::ST_IDLE:     if (trig_go) state_nxt = acs_pkg::ST_EXT_SAMP;
      acs_pkg::ST_SETUP:    if (cmd_dec) begin
        state_nxt = is_cfg ? acs_pkg::ST_CFG :
                    (samp_go ? acs_pkg::ST_SAMPLE : acs_pkg::ST_IDLE);
      end
      acs_pkg::ST_SAMPLE:   if (trig_fall) begin
        state_nxt = acs_pkg::ST_EXT_SAMP;
      end else if (sclk_fall && fall_nxt == samp_end) begin
        state_nxt = acs_pkg::ST_CONV;
      end
      acs_pkg::ST_CFG:      if (cfg_go) state_nxt = acs_pkg::ST_IDLE;
      acs_pkg::ST_EXT_SAMP: if (trig_rise) state_nxt = acs_pkg::ST_EXT_DLY;
      acs_pkg::ST_EXT_DLY:  if (dly_done) state_nxt = acs_pkg::ST_CONV;
      acs_pkg::ST_CONV:     if (conv_tick && conv_cnt_r == conv_last) begin
        state_nxt = acs_pkg::ST_FINISH;
      end
      acs_pkg::ST_FINISH:   if (fin_go) state_nxt = acs_pkg::ST_IDLE;
    endcase
    // a new frame aborts whatever runs
    if (frame_start) state_nxt = acs_pkg::ST_SETUP;
  end
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      {s1_r, s2_r, s3_r, stab_r, prev_r} <= {5{acs_pkg::PIN_RESET}};
      state_r <= acs_pkg::ST_IDLE;
      fall_r  <= '0;
      sh_r    <= '0;
      cfg_r   <= acs_pkg::CFG_RESET;
      div_r   <= '0;
      dly_r   <= '0;
      {conv_cnt_r, conv_falls_r} <= '0;
    end else begin
      {s1_r, s2_r, s3_r} <= {pins, s1_r, s2_r};
      stab_r  <= stab_nxt;
      prev_r  <= stab_r;
      state_r <= state_nxt;
      fall_r  <= frame_start ? 6'h00 : (sclk_fall ? fall_nxt : fall_r);
      sh_r    <= sclk_fall ? sh_nxt : sh_r;
      if (cfg_go) cfg_r <= sh_nxt;
      div_r   <= (state_r != acs_pkg::ST_CONV) ? 2'h0 : div_r + 2'(sclk_fall);
      dly_r   <= (state_nxt != state_r) ? 2'h0 : dly_r + 2'h1;
      conv_cnt_r <= (state_r != acs_pkg::ST_CONV) ? 5'h00 : conv_cnt_r + 5'(conv_tick);
      conv_falls_r <= (state_r != acs_pkg::ST_CONV) ? 7'h00 : conv_falls_r + 7'(sclk_fall);
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      {run_r, halt_r, armed_r, ext_mode_r, ext_cnt_r} <= '0;
      {cnt_r, idx_r, chan_r} <= '0;
      last_r <= '0;
    end else begin
      run_r  <= run_go || (run_r && !thr_hit);
      halt_r <= (thr_hit && mode == acs_pkg::MODE_SWEEP) ||
                (halt_r && !(cmd_dec && (is_read || is_cfg)));
      armed_r <= (cmd_dec && is_sel) || (armed_r && !(cmd_dec && (is_read || is_cfg)));
      if (state_nxt == acs_pkg::ST_EXT_SAMP && state_r != acs_pkg::ST_EXT_SAMP) begin
        ext_mode_r <= 1'b1;
        ext_cnt_r  <= 1'b0;
      end else if (frame_start && ext_mode_r && stab_r[acs_pkg::PIN_TRIG]) begin
        ext_cnt_r  <= 1'b1;
        ext_mode_r <= !ext_cnt_r;
      end
      cnt_r <= run_go ? 4'h0 : cnt_r + 4'(push);
      idx_r <= run_go ? 3'h0 : idx_r + 3'(push);
      // a select during a run is only a dummy
      if (cmd_dec && is_sel && (mode_one || !run_r)) chan_r <= cmd[2:0];
      if (fin_go) last_r <= i_adc_result;
    end
  end
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      out_sr_r              <= '0;
      o_serial_result_out   <= 1'b0;
      o_serial_result_oe    <= 1'b0;
      o_sample_en           <= 1'b0;
      o_adc_channel         <= '0;
      o_status_n            <= 1'b1;
      o_conv_busy_n         <= 1'b1;
      o_result_ready_flag_n <= 1'b1;
    end else begin
      // 12-bit variant sends four don't-care bits
      if (frame_start) begin
        out_sr_r <= {out_src[13:2], (i_res_12bit ? 2'b00 : out_src[1:0]), 2'b00};
      end else if (sclk_fall) begin
        out_sr_r <= {out_sr_r[14:0], 1'b0};
      end
      o_serial_result_out   <= frame_start ? out_src[13] : (sclk_fall ? out_sr_r[14] :
                               out_sr_r[15]);
      o_serial_result_oe    <= !stab_nxt[acs_pkg::PIN_CS];
      o_sample_en           <= state_nxt == acs_pkg::ST_SAMPLE ||
                               state_nxt == acs_pkg::ST_EXT_SAMP;
      o_adc_channel         <= cur_chan;
      o_conv_busy_n         <= busy_nxt;
      o_result_ready_flag_n <= flag_nxt;
      o_status_n            <= (pinsel && mode_one) ? busy_nxt : flag_nxt;
    end
  end
  acs_fifo #(.W(acs_pkg::RES_W), .D(acs_pkg::FIFO_D)) u_fifo (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_flush    (run_go), // new run overwrites old results
    .i_valid    (push),
    .o_ready    (fifo_in_rdy),
    .i_data     (i_adc_result),
    .o_valid    (fifo_out_vld),
    .i_ready    (pop),
    .o_data     (fifo_data)
  );
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  wire smp_step = state_r == acs_pkg::ST_SAMPLE && sclk_fall && !trig_fall && !frame_start;
  a_short_start: assert property (smp_step && !long_smp && fall_r == 6'h0F
    |=> state_r == acs_pkg::ST_CONV) else $error("short sampling did not end at fall 16");
  a_long_start: assert property (smp_step && long_smp && fall_r == 6'h2F
    |=> state_r == acs_pkg::ST_CONV) else $error("long sampling did not end at fall 48");
  a_no_early_conv: assert property (smp_step && fall_nxt != samp_end
    |=> state_r == acs_pkg::ST_SAMPLE) else $error("sampling ended early");
  a_ext_trig_conv: assert property (state_r == acs_pkg::ST_EXT_SAMP && trig_rise
    && !frame_start |=> state_r == acs_pkg::ST_EXT_DLY ##1
    (state_r == acs_pkg::ST_CONV || state_r == acs_pkg::ST_SETUP))
    else $error("trigger rise did not start conversion");
  a_conv_length: assert property ($rose(state_r == acs_pkg::ST_FINISH)
    |-> $past(conv_cnt_r) == conv_last) else $error("conversion clock count wrong");
  a_ext_div_four: assert property ($rose(state_r == acs_pkg::ST_FINISH)
    && !cfg_r[acs_pkg::CFG_INTCLK_BIT] |-> conv_falls_r == {conv_last + 5'h01, 2'b00})
    else $error("sclk divide wrong");
  a_busy_window: assert property (o_conv_busy_n ==
    !(state_r == acs_pkg::ST_CONV || state_r == acs_pkg::ST_FINISH))
    else $error("busy does not match conversion");
  a_flag_thresh: assert property (thr_hit |=> !o_result_ready_flag_n [*2] or
    frame_start) else $error("flag not raised at threshold");
  a_sweep_halt: assert property (halt_r && trig_fall && !frame_start
    |=> state_r != acs_pkg::ST_EXT_SAMP) else $error("halted sweep converted");
  a_ext_skip: assert property (cmd_dec && is_sel && ext_mode_r
    |=> state_r != acs_pkg::ST_SAMPLE) else $error("extended exit frame converted");
  a_dummy_sel: assert property (cmd_dec && is_sel && run_r && !mode_one
    |=> $stable(chan_r)) else $error("dummy select changed channel");
  a_cfg_hold: assert property ($changed(cfg_r) |-> $past(cfg_go))
    else $error("config changed without write");
  a_rsweep_free: assert property (thr_hit && mode == acs_pkg::MODE_RSWEEP
    |=> !halt_r) else $error("repeat sweep halted");
  c_short_conv: cover property (smp_step && !long_smp ##1 state_r == acs_pkg::ST_CONV);
  c_ext_conv: cover property (state_r == acs_pkg::ST_EXT_DLY ##1 state_r == acs_pkg::ST_CONV);
  c_thresh: cover property (thr_hit);
  c_fifo_read: cover property (pop);
endmodule

// *** include/acs_pkg.sv ***
// package: constants and types of the sample/conversion sequencer
package acs_pkg;
  // ----------------------------------------------------------------
  // frame and word sizes
  // ----------------------------------------------------------------
  localparam int         CMD_W        = 4;
  localparam int         CFG_W        = 12;
  localparam int         RES_W        = 14;
  localparam int         OUT_W        = 16;
  localparam int         FIFO_D       = 8;
  localparam logic [3:0] CMD_CFG_WR   = 4'hA;
  localparam logic [3:0] CMD_FIFO_RD  = 4'hE;
  // ----------------------------------------------------------------
  // config word layout and reset value
  // ----------------------------------------------------------------
  localparam int          CFG_THR_LSB    = 0;
  localparam int          CFG_PINSEL_BIT = 2;
  localparam int          CFG_SWEEP_LSB  = 3;
  localparam int          CFG_MODE_LSB   = 5;
  localparam int          CFG_INTCLK_BIT = 7;
  localparam int          CFG_LONG_BIT   = 8;
  localparam logic [11:0] CFG_RESET      = 12'h000;
  // pin vector order {sdi, osc, trig_n, sclk, fs, cs_n}
  localparam int          PIN_CS   = 0;
  localparam int          PIN_FS   = 1;
  localparam int          PIN_SCLK = 2;
  localparam int          PIN_TRIG = 3;
  localparam int          PIN_OSC  = 4;
  localparam int          PIN_SDI  = 5;
  localparam logic [5:0]  PIN_RESET = 6'h0B;
  // ----------------------------------------------------------------
  // timing counts
  // ----------------------------------------------------------------
  localparam logic [5:0] SETUP_FALLS  = 6'h04;
  localparam logic [5:0] SHORT_SAMPLE = 6'h0C;
  localparam logic [5:0] LONG_SAMPLE  = 6'h2C;
  localparam logic [4:0] CONV_CLK_14  = 5'h12;
  localparam logic [4:0] CONV_CLK_12  = 5'h0D;
  localparam logic [1:0] SCLK_DIV_LAST = 2'h3;
  localparam int         CLK_NS        = 25;
  localparam int         INT_DELAY_NS  = 15;
  localparam int         INT_DELAY_CYC = (INT_DELAY_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [1:0] DLY_LAST      = 2'(INT_DELAY_CYC - 1);
  localparam logic [3:0] THR_8 = 4'h8;
  localparam logic [3:0] THR_6 = 4'h6;
  localparam logic [3:0] THR_4 = 4'h4;
  localparam logic [3:0] THR_2 = 4'h2;
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ONE = 2'b00, MODE_REPEAT = 2'b01, MODE_SWEEP = 2'b10, MODE_RSWEEP = 2'b11
  } acs_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_SETUP = 3'b001, ST_SAMPLE = 3'b010, ST_CFG = 3'b011,
    ST_EXT_SAMP = 3'b100, ST_EXT_DLY = 3'b101, ST_CONV = 3'b110, ST_FINISH = 3'b111
  } acs_state_t;
endpackage

// *** verif/acs_host_model.sv ***
// host model: serial master driving the sequencer link pins
module acs_host_model (
  // link pins
  output logic      o_cs_n,
  output logic      o_frame_sync,
  output logic      o_sclk,
  output logic      o_sdi,
  output logic      o_trig_n,
  // result line
  input  wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------
  // idle levels
  // ----------
  // chip select is the only trigger, frame_sync parked high
  // trigger pulsed only after a whole frame, long past the 11th sclk
  initial begin
    o_cs_n       = 1'b1;
    o_frame_sync = 1'b1;
    o_sclk       = 1'b0;
    o_sdi        = 1'b0;
    o_trig_n     = 1'b1;
  end
  // ----------
  // one frame
  // ----------
  // command nibble then config bits, msb first
  // sclk stands low outside frames; extra clocks let a conversion end
  task automatic frame(input logic [15:0] word, input int nclk, output logic [15:0] rx);
    rx = 16'h0000;
    o_cs_n = 1'b0;
    #300;
    // data moves on the rising edge so it stands across the sampling fall
    for (int i = 0; i < nclk; i++) begin
      #100 o_sclk = 1'b1;
      o_sdi = (i < 16) ? word[15-i] : ~o_sdi;
      #100;
      if (i < 16) rx[15-i] = i_sdo;
      o_sclk = 1'b0;
    end
    #300 o_cs_n = 1'b1;
    // released line must not keep a stale level
    o_sdi = ~o_sdi;
    #400;
  endtask
  // extended-sampling pulse; waits out the conversion that follows
  task automatic pulse(input int low_ns);
    o_trig_n = 1'b0;
    #(low_ns);
    o_trig_n = 1'b1;
    #2400;
  endtask
endmodule

// *** verif/test_acs_sequencer.sv ***
// self-checking bench of the sample/conversion sequencer
module test_acs_sequencer;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int          TIMEOUT = 60000;
  localparam logic [11:0] ROW_CFG [4] = '{12'h004, 12'h100, 12'h084, 12'h000};
  localparam int          ROW_SMP [4] = '{12, 44, 12, 12};
  localparam int          ROW_BSY [4] = '{72, 72, 9, 52};
  logic        clk, rst, cs_n, fs, sclk, serial_cmd_in, trig_n, osc;
  logic        serial_result_out, sdo_oe, res12, smp_en, stat_n, busy_n, flag_n;
  logic [2:0]  chan;
  logic [13:0] adc;
  logic [15:0] rx;
  int          cycles, busy_cnt, smp_cnt, stat_cnt, d_smp, d_bsy, d_st;
  int          miscompares, checks_done;

  acs_sequencer acs_sequencer_inst (
    .i_core_clk(clk), .i_rst(rst), .i_cs_n(cs_n), .i_frame_sync(fs), .i_sclk(sclk),
    .i_serial_cmd_in(serial_cmd_in), .i_ext_sample_trigger_n(trig_n), .i_on_chip_conv_clock(osc),
    .o_serial_result_out(serial_result_out), .o_serial_result_oe(sdo_oe), .i_adc_result(adc),
    .i_res_12bit(res12), .o_sample_en(smp_en), .o_adc_channel(chan), .o_status_n(stat_n),
    .o_conv_busy_n(busy_n), .o_result_ready_flag_n(flag_n));
  acs_host_model acs_host_model_inst (
    .o_cs_n(cs_n), .o_frame_sync(fs), .o_sclk(sclk), .o_sdi(serial_cmd_in), .o_trig_n(trig_n),
    .i_sdo(serial_result_out));

  // ----------
  // clocks and monitors
  // ----------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // oscillator free-running, phase unrelated to the core clock
  initial begin
    osc = 1'b0;
    #7;
    forever #50 osc = ~osc;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (busy_n === 1'b0) busy_cnt <= busy_cnt + 1;
    if (smp_en === 1'b1) smp_cnt <= smp_cnt + 1;
    if (stat_n === 1'b0) stat_cnt <= stat_cnt + 1;
    if (cycles == TIMEOUT) begin
      miscompares++;
      conclude();
    end
  end

  // ----------
  // helpers
  // ----------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic set_in(input logic r12, input logic [13:0] a);
    @(posedge clk);
    #2;
    res12 = r12;
    adc = a;
  endtask
  task automatic cfg(input logic [11:0] w);
    acs_host_model_inst.frame({acs_pkg::CMD_CFG_WR, w}, 16, rx);
  endtask
  task automatic rd();
    acs_host_model_inst.frame({acs_pkg::CMD_FIFO_RD, 12'h000}, 16, rx);
  endtask
  // select frame long enough for a long sample plus a full conversion
  task automatic sel(input logic [3:0] ch);
    int s0, b0, t0;
    s0 = smp_cnt;
    b0 = busy_cnt;
    t0 = stat_cnt;
    acs_host_model_inst.frame({ch, 12'h000}, 128, rx);
    d_smp = smp_cnt - s0;
    d_bsy = busy_cnt - b0;
    d_st = stat_cnt - t0;
  endtask

  // ----------
  // scenarios
  // ----------
  task automatic t_reset();
    chk("oe", 16'(sdo_oe), 16'h0000);
    chk("idle busy flag", 16'({busy_n, flag_n}), 16'h0003);
    chk("sample_en", 16'(smp_en), 16'h0000);
  endtask
  // sample and conversion lengths in sclk periods, per clock and mode
  task automatic t_timing();
    for (int r = 0; r < 4; r++) begin
      set_in(r == 3, 14'h2A5C | 14'(r == 3));
      cfg(ROW_CFG[r]);
      if (r > 0) chk("prev result", rx, 16'hA970);
      sel(4'h3);
      chk("sample sclks", 16'((d_smp + 4) / 8), 16'(ROW_SMP[r]));
      chk("conv length", 16'((d_bsy + 4) / 8), 16'(ROW_BSY[r]));
      if (ROW_CFG[r][2]) chk("status as busy", 16'(d_st), 16'(d_bsy));
      else chk("status as flag", 16'({flag_n, stat_n}), 16'h0000);
    end
  endtask
  // every threshold code; later selects carry a different channel
  task automatic t_repeat();
    for (int t = 0; t < 4; t++) begin
      cfg(12'h020 | 12'(t));
      if (t == 0) chk("pad bits", 16'(rx[3:0]), 16'h0000);
      for (int k = 0; k < 8 - 2 * t; k++) begin
        set_in(1'b0, 14'h1000 + 14'(k));
        sel(k == 0 ? 4'h5 : 4'h1);
        chk("channel", 16'(chan), 16'h0005);
        chk("flag_n", 16'(flag_n), 16'(k < 7 - 2 * t));
      end
      for (int k = 0; k < 8 - 2 * t; k++) begin
        rd();
        chk("fifo word", rx, {14'h1000 + 14'(k), 2'b00});
      end
    end
  endtask
  // sweep 0-2-4-6 to threshold 4, halt, then repeat sweep without read
  task automatic t_sweep();
    cfg(12'h04A);
    for (int k = 0; k < 4; k++) begin
      sel(4'h7);
      // channel output already points at the next sweep step
      chk("sweep channel", 16'(chan), 16'((2 * k + 2) % 8));
    end
    chk("flag_n", 16'(flag_n), 16'h0000);
    sel(4'h7);
    chk("halted conv", 16'(d_bsy), 16'h0000);
    rd();
    chk("sweep head", rx, 16'h4004);
    cfg(12'h06A);
    for (int k = 0; k < 5; k++) sel(4'h7);
    chk("resweep conv", 16'((d_bsy + 4) / 8), 16'h0048);
    chk("resweep channel", 16'(chan), 16'h0002);
  endtask
  // trigger-driven conversion, then the two frames that leave extended mode
  task automatic t_ext();
    int s0, b0;
    cfg(12'h080);
    sel(4'h3);
    s0 = smp_cnt;
    b0 = busy_cnt;
    acs_host_model_inst.pulse(2000);
    chk("ext sample", 16'((smp_cnt - s0 + 4) / 8), 16'h000A);
    chk("ext conv", 16'((busy_cnt - b0 + 4) / 8), 16'h0009);
    sel(4'h3);
    chk("ext first frame", 16'(d_bsy + d_smp), 16'h0000);
    sel(4'h3);
    chk("ext left", 16'((d_bsy + 4) / 8), 16'h0009);
  endtask

  initial begin
    rst = 1'b1;
    res12 = 1'b0;
    adc = 14'h0000;
    repeat (6) @(posedge clk);
    #2;
    rst = 1'b0;
    repeat (8) @(posedge clk);
    t_reset();
    t_timing();
    t_repeat();
    t_sweep();
    t_ext();
    conclude();
  end
endmodule
